// ===== rtl/sfr_core_pkg.sv
// Constants and types shared by the core special function register block
package sfr_core_pkg;

    // ****************************************
    // Register addresses
    // ****************************************
    localparam logic [7:0] ADDR_IND_PORT_A  = 8'h00;
    localparam logic [7:0] ADDR_IND_PTR_A   = 8'h01;
    localparam logic [7:0] ADDR_IND_PORT_B  = 8'h02;
    localparam logic [7:0] ADDR_IND_PTR_B   = 8'h03;
    localparam logic [7:0] ADDR_BANK_SELECT = 8'h04;
    localparam logic [7:0] ADDR_WORKING     = 8'h05;
    localparam logic [7:0] ADDR_PC_LOW      = 8'h06;
    localparam logic [7:0] ADDR_TBL_PTR_LO  = 8'h07;
    localparam logic [7:0] ADDR_TBL_RESULT  = 8'h08;
    localparam logic [7:0] ADDR_TBL_PTR_HI  = 8'h09;
    localparam logic [7:0] ADDR_FLAGS       = 8'h0a;
    // Special function space ends below this address
    localparam logic [7:0] ADDR_GP_BASE     = 8'h80;

    // ****************************************
    // Field positions and reset values
    // ****************************************
    localparam int FLAG_SC  = 7;
    localparam int FLAG_CZ  = 6;
    localparam int FLAG_TO  = 5;
    localparam int FLAG_PD  = 4;
    localparam int FLAG_OV  = 3;
    localparam int FLAG_Z   = 2;
    localparam int FLAG_AC  = 1;
    localparam int FLAG_C   = 0;
    localparam logic [7:0] FLAGS_SW_MASK   = 8'h0f;
    localparam logic [7:0] FLAGS_RESET     = 8'h00;
    localparam logic       BANK_RESET      = 1'b0;
    localparam logic [7:0] UNUSED_READ     = 8'h00;
    localparam int         PC_WIDTH        = 13;
    localparam int         TBL_PTR_HI_BITS = 5;

    // ****************************************
    // Instruction classes from the execute unit
    // ****************************************
    typedef enum logic [2:0] {
        OP_OTHER    = 3'h0,
        OP_ADD      = 3'h1,
        OP_SUB      = 3'h2,
        OP_SUB_BORR = 3'h3,
        OP_LOGIC    = 3'h4,
        OP_ROT_C    = 3'h5
    } alu_class_t;

endpackage : sfr_core_pkg

// ===== rtl/flag_calc.sv
// Combinational arithmetic flag computation for one ALU result
module flag_calc (
    input  wire logic [7:0]                result_i,
    input  wire logic                      carry_out_i,
    input  wire logic                      carry_msb_in_i,
    input  wire logic                      half_carry_i,
    input  wire sfr_core_pkg::alu_class_t  op_class_i,
    input  wire logic                      chained_zero_i,
    output logic                           zero_o,
    output logic                           signed_wrap_o,
    output logic                           signed_compare_o,
    output logic                           chained_zero_o
);

    always_comb begin
        zero_o           = (result_i == 8'h00);
        signed_wrap_o    = carry_msb_in_i ^ carry_out_i;
        signed_compare_o = signed_wrap_o ^ result_i[7];
        unique case (op_class_i)
            sfr_core_pkg::OP_SUB: begin
                chained_zero_o = zero_o;
            end
            sfr_core_pkg::OP_SUB_BORR: begin
                chained_zero_o = chained_zero_i & zero_o;
            end
            default: begin
                chained_zero_o = chained_zero_i;
            end
        endcase
    end

endmodule : flag_calc

// ===== rtl/bank_decode.sv
// Data memory bank decode for direct and indirect accesses
module bank_decode (
    input  wire logic [7:0] addr_i,
    input  wire logic       indirect_i,
    input  wire logic       via_port_b_i,
    input  wire logic       bank_select_bit_i,
    output logic            is_sfr_o,
    output logic            bank_o
);

    always_comb begin
        is_sfr_o = (addr_i < sfr_core_pkg::ADDR_GP_BASE);
        // only second pointer pair uses bank
        bank_o   = indirect_i & via_port_b_i & bank_select_bit_i & ~is_sfr_o;
    end

endmodule : bank_decode

// ===== rtl/sfr_core.sv
// Core special function registers: bank select, status flags, pc low, table result
//
// Function
// - bank select bit chooses bank zero/one
// - reset clears bank except sleep watchdog reset
// - special registers reachable from either bank
// - direct accesses always reach bank zero
// - upper seven bank bits read zero
// - pc low write jumps within page
// - pc low write inserts dummy cycle
// - table read splits word high/low
// - flag layout, upper four read-only
// - software writes keep system flags
// - watchdog timeout flag set and cleared
// - sleep flag set by sleep instruction
// - signed compare is wrap xor msb
// - chained zero follows subtract class
// - carry from add, no-borrow, rotate
// - nibble carry from low nibble
// - zero flag on zero result
// - signed wrap from msb carries
// - flags never auto-saved on calls
// - no register-to-register moves
// - second pointer pair uses bank bit
// - unused addresses read zero
module sfr_core (
    input  wire logic                     clk_i,
    input  wire logic                     rstn_i,
    // Reset cause: high when the reset is a watchdog timeout from sleep
    input  wire logic                     wdt_sleep_reset_i,
    // Register access from the execute unit
    input  wire logic [7:0]               addr_i,
    input  wire logic                     wr_en_i,
    input  wire logic                     rd_en_i,
    input  wire logic [7:0]               wdata_i,
    input  wire logic                     indirect_i,
    input  wire logic                     via_port_b_i,
    // ALU result of the instruction in execute
    input  wire logic                     alu_valid_i,
    input  wire sfr_core_pkg::alu_class_t op_class_i,
    input  wire logic [7:0]               result_i,
    input  wire logic                     carry_out_i,
    input  wire logic                     carry_msb_in_i,
    input  wire logic                     half_carry_i,
    input  wire logic                     rot_carry_i,
    // System events
    input  wire logic                     wdt_timeout_i,
    input  wire logic                     wdt_clear_instr_i,
    input  wire logic                     sleep_instr_i,
    // Program counter and table read
    input  wire logic [12:0]              pc_i,
    input  wire logic                     table_read_i,
    input  wire logic [15:0]              table_word_i,

    output logic [7:0]                    rdata_o,
    output logic                          bank_o,
    output logic                          is_sfr_o,
    output logic                          bank_select_bit_o,
    output logic [7:0]                    flags_o,
    output logic                          pc_load_o,
    output logic [12:0]                   pc_target_o,
    output logic                          dummy_cycle_o,
    output logic [7:0]                    table_low_o,
    output logic                          table_low_valid_o,
    output logic [12:0]                   table_addr_o
);

    // ****************************************
    // Reset release
    // ****************************************
    logic [1:0] rst_sync_reg;
    logic       rst_n;

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rst_sync_reg <= 2'h0;
        end else begin
            rst_sync_reg <= {rst_sync_reg[0], 1'b1};
        end
    end

    assign rst_n = rst_sync_reg[1];

    // ****************************************
    // State
    // ****************************************
    typedef struct packed {
        logic        started;
        logic [7:0]  flags;
        logic [7:0]  tbl_ptr_lo;
        logic [4:0]  tbl_ptr_hi;
        logic [7:0]  tbl_result;
        logic [7:0]  rdata;
        logic        bank;
        logic        is_sfr;
        logic        pc_load;
        logic [12:0] pc_target;
        logic        dummy;
        logic [7:0]  tbl_low;
        logic        tbl_low_valid;
    } state_t;

    state_t state_reg;
    state_t state_next;

    // ****************************************
    // Bank select
    // ****************************************
    // No async reset: a sleep watchdog wake keeps it
    logic   bank_sel_reg;
    logic   bank_sel_next;

    // ****************************************
    // Helpers
    // ****************************************
    logic fz;
    logic fov;
    logic fsc;
    logic fcz;
    logic dec_sfr;
    logic dec_bank;

    flag_calc u_flag_calc (
        .result_i         (result_i),
        .carry_out_i      (carry_out_i),
        .carry_msb_in_i   (carry_msb_in_i),
        .half_carry_i     (half_carry_i),
        .op_class_i       (op_class_i),
        .chained_zero_i   (state_reg.flags[sfr_core_pkg::FLAG_CZ]),
        .zero_o           (fz),
        .signed_wrap_o    (fov),
        .signed_compare_o (fsc),
        .chained_zero_o   (fcz)
    );

    bank_decode u_bank_decode (
        .addr_i            (addr_i),
        .indirect_i        (indirect_i),
        .via_port_b_i      (via_port_b_i),
        .bank_select_bit_i (bank_sel_reg),
        .is_sfr_o          (dec_sfr),
        .bank_o            (dec_bank)
    );


    function automatic logic hit(input logic [7:0] a, input logic [7:0] target);
        hit = (a == target);
    endfunction : hit

    logic arith;
    assign arith = (op_class_i == sfr_core_pkg::OP_ADD) ||
                   (op_class_i == sfr_core_pkg::OP_SUB) ||
                   (op_class_i == sfr_core_pkg::OP_SUB_BORR);

    // ****************************************
    // Next state
    // ****************************************
    always_comb begin
        state_next               = state_reg;
        bank_sel_next            = bank_sel_reg;
        state_next.started       = 1'b1;
        state_next.pc_load       = 1'b0;
        state_next.dummy         = 1'b0;
        state_next.tbl_low_valid = 1'b0;
        state_next.bank          = dec_bank;
        state_next.is_sfr        = dec_sfr;


        // first cycle after reset picks bank by cause
        if (!state_reg.started && !wdt_sleep_reset_i) begin
            bank_sel_next = sfr_core_pkg::BANK_RESET;
        end

        state_next.rdata = sfr_core_pkg::UNUSED_READ;

        if (rd_en_i && !indirect_i) begin
            unique case (1'b1)
                hit(addr_i, sfr_core_pkg::ADDR_BANK_SELECT):
                    state_next.rdata = {7'h00, bank_sel_reg};
                hit(addr_i, sfr_core_pkg::ADDR_FLAGS):
                    state_next.rdata = state_reg.flags;
                hit(addr_i, sfr_core_pkg::ADDR_PC_LOW):
                    state_next.rdata = pc_i[7:0];
                hit(addr_i, sfr_core_pkg::ADDR_TBL_PTR_LO):
                    state_next.rdata = state_reg.tbl_ptr_lo;
                hit(addr_i, sfr_core_pkg::ADDR_TBL_PTR_HI):
                    state_next.rdata = {3'h0, state_reg.tbl_ptr_hi};
                hit(addr_i, sfr_core_pkg::ADDR_TBL_RESULT):
                    state_next.rdata = state_reg.tbl_result;
                default:
                    state_next.rdata = sfr_core_pkg::UNUSED_READ;
            endcase
        end

        // ALU flags land at end of execute
        if (alu_valid_i) begin
            state_next.flags[sfr_core_pkg::FLAG_Z] = fz;

            if (arith) begin
                state_next.flags[sfr_core_pkg::FLAG_C]  = carry_out_i;
                state_next.flags[sfr_core_pkg::FLAG_AC] = half_carry_i;
                state_next.flags[sfr_core_pkg::FLAG_OV] = fov;
                state_next.flags[sfr_core_pkg::FLAG_SC] = fsc;
            end
            if (op_class_i == sfr_core_pkg::OP_ROT_C) begin
                state_next.flags[sfr_core_pkg::FLAG_C] = rot_carry_i;
            end

            state_next.flags[sfr_core_pkg::FLAG_CZ] = fcz;
        end

        // Direct register writes; indirect ports reach no register here
        // writes only from wdata_i
        if (wr_en_i && !indirect_i) begin
            if (hit(addr_i, sfr_core_pkg::ADDR_BANK_SELECT)) begin
                bank_sel_next = wdata_i[0];
            end

            if (hit(addr_i, sfr_core_pkg::ADDR_FLAGS)) begin
                state_next.flags = (state_next.flags & ~sfr_core_pkg::FLAGS_SW_MASK) |
                                   (wdata_i & sfr_core_pkg::FLAGS_SW_MASK);
            end

            if (hit(addr_i, sfr_core_pkg::ADDR_TBL_PTR_LO)) begin
                state_next.tbl_ptr_lo = wdata_i;
            end

            if (hit(addr_i, sfr_core_pkg::ADDR_TBL_PTR_HI)) begin
                state_next.tbl_ptr_hi = wdata_i[sfr_core_pkg::TBL_PTR_HI_BITS-1:0];
            end

            if (hit(addr_i, sfr_core_pkg::ADDR_PC_LOW)) begin
                state_next.pc_load   = 1'b1;
                state_next.pc_target = {pc_i[12:8], wdata_i};
                state_next.dummy     = 1'b1;
            end
        end

        if (table_read_i) begin
            state_next.tbl_result    = table_word_i[15:8];
            state_next.tbl_low       = table_word_i[7:0];
            state_next.tbl_low_valid = 1'b1;
        end

        // Sleep and clear take priority over a same-cycle timeout
        // watchdog flag set
        if (wdt_timeout_i) begin
            state_next.flags[sfr_core_pkg::FLAG_TO] = 1'b1;
        end

        if (sleep_instr_i) begin
            state_next.flags[sfr_core_pkg::FLAG_PD] = 1'b1;
            state_next.flags[sfr_core_pkg::FLAG_TO] = 1'b0;
        end

        if (wdt_clear_instr_i) begin
            state_next.flags[sfr_core_pkg::FLAG_TO] = 1'b0;
            state_next.flags[sfr_core_pkg::FLAG_PD] = 1'b0;
        end
    end

    // ****************************************
    // Registers
    // ****************************************
    // Power-up clears flags; bank bit kept across reset so a sleep wake can retain it
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            state_reg.started       <= 1'b0;
            state_reg.flags         <= sfr_core_pkg::FLAGS_RESET;
            state_reg.tbl_ptr_lo    <= 8'h00;
            state_reg.tbl_ptr_hi    <= 5'h00;
            state_reg.tbl_result    <= 8'h00;
            state_reg.rdata         <= 8'h00;
            state_reg.bank          <= 1'b0;
            state_reg.is_sfr        <= 1'b0;
            state_reg.pc_load       <= 1'b0;
            state_reg.pc_target     <= 13'h0000;
            state_reg.dummy         <= 1'b0;
            state_reg.tbl_low       <= 8'h00;
            state_reg.tbl_low_valid <= 1'b0;
        end else begin
            state_reg.started       <= state_next.started;
            state_reg.flags         <= state_next.flags;
            state_reg.tbl_ptr_lo    <= state_next.tbl_ptr_lo;
            state_reg.tbl_ptr_hi    <= state_next.tbl_ptr_hi;
            state_reg.tbl_result    <= state_next.tbl_result;
            state_reg.rdata         <= state_next.rdata;
            state_reg.bank          <= state_next.bank;
            state_reg.is_sfr        <= state_next.is_sfr;
            state_reg.pc_load       <= state_next.pc_load;
            state_reg.pc_target     <= state_next.pc_target;
            state_reg.dummy         <= state_next.dummy;
            state_reg.tbl_low       <= state_next.tbl_low;
            state_reg.tbl_low_valid <= state_next.tbl_low_valid;
        end
    end


    always_ff @(posedge clk_i) begin
        bank_sel_reg <= bank_sel_next;
    end

    // ****************************************
    // Outputs
    // ****************************************
    assign rdata_o           = state_reg.rdata;
    assign bank_o            = state_reg.bank;
    assign is_sfr_o          = state_reg.is_sfr;
    assign bank_select_bit_o = bank_sel_reg;
    assign flags_o           = state_reg.flags;
    assign pc_load_o         = state_reg.pc_load;
    assign pc_target_o       = state_reg.pc_target;
    assign dummy_cycle_o     = state_reg.dummy;
    assign table_low_o       = state_reg.tbl_low;
    assign table_low_valid_o = state_reg.tbl_low_valid;

    assign table_addr_o      = {state_reg.tbl_ptr_hi, state_reg.tbl_ptr_lo};

endmodule : sfr_core

// ===== dv/exec_unit_model.sv
// Behavioural execute unit: produces ALU results and carries from two operands
module exec_unit_model (
    input  wire logic [7:0]               a_i,
    input  wire logic [7:0]               b_i,
    input  wire sfr_core_pkg::alu_class_t class_i,
    input  wire logic                     carry_i,
    output logic [7:0]                    result_o,
    output logic                          carry_out_o,
    output logic                          carry_msb_in_o,
    output logic                          half_carry_o,
    output logic                          rot_carry_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic       sub;
    logic       cin;
    logic [7:0] opb;
    logic [8:0] sum;
    logic [7:0] lo7;
    logic [4:0] nib;
    // Subtract as a plus inverted b, borrow as carry in
    assign sub = class_i inside {sfr_core_pkg::OP_SUB, sfr_core_pkg::OP_SUB_BORR};
    assign opb = sub ? ~b_i : b_i;
    assign cin = (class_i == sfr_core_pkg::OP_SUB) |
                 ((class_i == sfr_core_pkg::OP_SUB_BORR) & carry_i);
    assign sum = {1'b0, a_i} + {1'b0, opb} + {8'h00, cin};
    assign lo7 = {1'b0, a_i[6:0]} + {1'b0, opb[6:0]} + {7'h00, cin};
    assign nib = {1'b0, a_i[3:0]} + {1'b0, opb[3:0]} + {4'h0, cin};
    assign result_o = (class_i == sfr_core_pkg::OP_LOGIC) ? (a_i & b_i) :
                      (class_i == sfr_core_pkg::OP_ROT_C) ? {a_i[6:0], carry_i} : sum[7:0];
    assign carry_out_o = sum[8];
    assign carry_msb_in_o = lo7[7];
    assign half_carry_o = nib[4];
    assign rot_carry_o = a_i[7];
endmodule : exec_unit_model

// ===== dv/sfr_core_sva.sv
// Port-level assertions for the core special function registers
module sfr_core_sva (
    input logic                     clk_i,
    input logic                     rstn_i,
    input logic [7:0]               addr_i,
    input logic                     wr_en_i,
    input logic                     rd_en_i,
    input logic [7:0]               wdata_i,
    input logic                     indirect_i,
    input logic                     via_port_b_i,
    input logic                     alu_valid_i,
    input sfr_core_pkg::alu_class_t op_class_i,
    input logic [7:0]               result_i,
    input logic                     wdt_timeout_i,
    input logic                     wdt_clear_instr_i,
    input logic                     sleep_instr_i,
    input logic [12:0]              pc_i,
    input logic                     table_read_i,
    input logic [15:0]              table_word_i,
    input logic [7:0]               rdata_o,
    input logic                     bank_o,
    input logic                     is_sfr_o,
    input logic                     bank_select_bit_o,
    input logic [7:0]               flags_o,
    input logic                     pc_load_o,
    input logic [12:0]              pc_target_o,
    input logic                     dummy_cycle_o,
    input logic [7:0]               table_low_o,
    input logic                     table_low_valid_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic acc, dir, fl_wr, pc_wr, arith;
    assign acc = rd_en_i | wr_en_i;
    assign dir = acc & !indirect_i;
    assign fl_wr = wr_en_i & dir & (addr_i == sfr_core_pkg::ADDR_FLAGS);
    assign pc_wr = wr_en_i & dir & (addr_i == sfr_core_pkg::ADDR_PC_LOW);
    assign arith = op_class_i inside {sfr_core_pkg::OP_ADD, sfr_core_pkg::OP_SUB,
                                      sfr_core_pkg::OP_SUB_BORR};
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rstn_i);
    sequence s_jump;
        pc_load_o && pc_target_o == {$past(pc_i[12:8]), $past(wdata_i)};
    endsequence
    sequence s_lone_write;
        pc_wr ##1 !pc_wr;
    endsequence
    a_pc_jump: assert property (pc_wr |=> s_jump)
        else $error("pc jump wrong");
    a_dummy_once: assert property (s_lone_write |-> dummy_cycle_o ##1 !dummy_cycle_o)
        else $error("dummy not one pulse");
    a_bank_readback: assert property (rd_en_i && dir && addr_i == sfr_core_pkg::ADDR_BANK_SELECT
        |=> rdata_o == {7'h00, $past(bank_select_bit_o)})
        else $error("bank read wrong");
    a_direct_bank0: assert property (dir |=> !bank_o)
        else $error("direct not bank 0");
    a_port_b_bank: assert property (acc && indirect_i && via_port_b_i
        && addr_i >= sfr_core_pkg::ADDR_GP_BASE |=> bank_o == $past(bank_select_bit_o))
        else $error("port b bank wrong");
    a_sfr_decode: assert property (acc |=> is_sfr_o == ($past(addr_i) < 8'h80))
        else $error("sfr decode wrong");
    a_sw_flags: assert property (fl_wr && !alu_valid_i && !wdt_timeout_i && !sleep_instr_i
        && !wdt_clear_instr_i |=> flags_o == {$past(flags_o[7:4]), $past(wdata_i[3:0])})
        else $error("flag write wrong");
    a_clear_wins: assert property (wdt_clear_instr_i |=> flags_o[5:4] == 2'b00)
        else $error("clear left flags");
    a_sleep_sets: assert property (sleep_instr_i && !wdt_clear_instr_i
        |=> flags_o[5:4] == 2'b01)
        else $error("sleep flags wrong");
    a_timeout_sets: assert property (wdt_timeout_i && !sleep_instr_i && !wdt_clear_instr_i
        |=> flags_o[5] && flags_o[4] == $past(flags_o[4]))
        else $error("timeout flag not set");
    a_table_split: assert property (table_read_i
        |=> table_low_valid_o && table_low_o == $past(table_word_i[7:0]))
        else $error("table low byte wrong");
    a_compare_xor: assert property (alu_valid_i && arith && !fl_wr
        |=> flags_o[7] == (flags_o[3] ^ $past(result_i[7])))
        else $error("compare flag wrong");
    a_zero_flag: assert property (alu_valid_i && !fl_wr
        |=> flags_o[2] == ($past(result_i) == 8'h00))
        else $error("zero flag wrong");
endmodule : sfr_core_sva

bind sfr_core sfr_core_sva u_sva (.*);

// ===== dv/status_flags_and_bank_select_bench.sv
// Self-checking bench for the core special function registers
module status_flags_and_bank_select_bench;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {
        logic [7:0]               a;
        logic [7:0]               b;
        sfr_core_pkg::alu_class_t cls;
        logic [7:0]               exp;
    } alu_row_t;
    logic clk_i, rstn_i, wdt_sleep_reset_i, wr_en_i, rd_en_i, indirect_i, via_port_b_i;
    logic alu_valid_i, carry_out_i, carry_msb_in_i, half_carry_i, rot_carry_i;
    logic wdt_timeout_i, wdt_clear_instr_i, sleep_instr_i, table_read_i;
    logic bank_o, is_sfr_o, bank_select_bit_o, pc_load_o, dummy_cycle_o, table_low_valid_o;
    logic [7:0]               addr_i, wdata_i, result_i, rdata_o, flags_o, table_low_o, op_a, op_b;
    logic [12:0]              pc_i, pc_target_o, table_addr_o;
    logic [15:0]              table_word_i;
    sfr_core_pkg::alu_class_t op_class_i;
    int                       n_errors = 0;
    int                       n_checks = 0;
    // Add overflow, add wrap, subtract, borrow chain, logic zero, rotate
    alu_row_t rows [6] = '{
        '{8'h7f, 8'h01, sfr_core_pkg::OP_ADD, 8'h0a},
        '{8'hff, 8'h01, sfr_core_pkg::OP_ADD, 8'h07},
        '{8'h05, 8'h05, sfr_core_pkg::OP_SUB, 8'h47},
        '{8'h00, 8'h01, sfr_core_pkg::OP_SUB_BORR, 8'h80},
        '{8'hf0, 8'h0f, sfr_core_pkg::OP_LOGIC, 8'h84},
        '{8'h81, 8'h00, sfr_core_pkg::OP_ROT_C, 8'h81}};

    sfr_core DUT (.*);
    exec_unit_model u_exec (.a_i(op_a), .b_i(op_b), .class_i(op_class_i), .carry_i(flags_o[0]),
        .result_o(result_i), .carry_out_o(carry_out_i), .carry_msb_in_o(carry_msb_in_i),
        .half_carry_o(half_carry_i), .rot_carry_o(rot_carry_i));

    initial begin
        clk_i = 1'b0;
        forever #10 clk_i = ~clk_i;
    end

    // ****************************************
    // Shared tasks
    // ****************************************
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic do_reset(input logic cause);
        @(negedge clk_i);
        wdt_sleep_reset_i = cause;
        rstn_i = 1'b0;
        repeat (10) @(negedge clk_i);
        rstn_i = 1'b1;
        repeat (3) @(negedge clk_i);
        wdt_sleep_reset_i = 1'b0;
    endtask : do_reset

    // One-cycle access
    task automatic acc(input logic [7:0] a, input logic [7:0] d, input logic w,
                       input logic ind, input logic pb);
        @(negedge clk_i);
        addr_i = a;
        wdata_i = d;
        wr_en_i = w;
        rd_en_i = !w;
        indirect_i = ind;
        via_port_b_i = pb;
        @(negedge clk_i);
        {wr_en_i, rd_en_i, indirect_i, via_port_b_i} = 4'h0;
    endtask : acc

    task automatic ev(input logic [2:0] s, input logic [7:0] exp);
        @(negedge clk_i);
        {wdt_timeout_i, sleep_instr_i, wdt_clear_instr_i} = s;
        @(negedge clk_i);
        {wdt_timeout_i, sleep_instr_i, wdt_clear_instr_i} = 3'h0;
        chk(flags_o, exp);
    endtask : ev

    task automatic complete_run;
        $display("checks=%0d errors=%0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : complete_run

    initial begin
        #40000;
        n_errors++;
        complete_run();
    end

    initial begin
        {rstn_i, wdt_sleep_reset_i, wr_en_i, rd_en_i, indirect_i, via_port_b_i} = 6'h00;
        {alu_valid_i, wdt_timeout_i, wdt_clear_instr_i, sleep_instr_i, table_read_i} = 5'h00;
        {addr_i, wdata_i, op_a, op_b} = 32'h0;
        op_class_i = sfr_core_pkg::OP_OTHER;
        pc_i = 13'h1200;
        table_word_i = 16'h0000;
        do_reset(1'b0);
        chk(flags_o, 8'h00);
        chk(bank_select_bit_o, 16'h0000);
        $display("reset done");
        // ****************************************
        // ALU flag rows
        // ****************************************
        for (int i = 0; i < 6; i++) begin
            @(negedge clk_i);
            op_a = rows[i].a;
            op_b = rows[i].b;
            op_class_i = rows[i].cls;
            alu_valid_i = 1'b1;
            @(negedge clk_i);
            alu_valid_i = 1'b0;
            chk(flags_o, rows[i].exp);
        end
        $display("alu rows done");
        // ****************************************
        // Hand-written cases
        // ****************************************
        acc(sfr_core_pkg::ADDR_FLAGS, 8'hf5, 1'b1, 1'b0, 1'b0);
        chk(flags_o, 8'h85);
        ev(3'b100, 8'ha5);
        ev(3'b010, 8'h95);
        ev(3'b100, 8'hb5);
        ev(3'b001, 8'h85);
        acc(sfr_core_pkg::ADDR_BANK_SELECT, 8'hff, 1'b1, 1'b0, 1'b0);
        chk(bank_select_bit_o, 16'h0001);
        acc(sfr_core_pkg::ADDR_BANK_SELECT, 8'h00, 1'b0, 1'b0, 1'b0);
        chk(rdata_o, 8'h01);
        acc(8'h90, 8'h00, 1'b0, 1'b0, 1'b0);
        chk({is_sfr_o, bank_o}, 16'h0000);
        acc(8'h90, 8'h00, 1'b0, 1'b1, 1'b1);
        chk(bank_o, 16'h0001);
        acc(8'h90, 8'h00, 1'b0, 1'b1, 1'b0);
        chk(bank_o, 16'h0000);
        acc(sfr_core_pkg::ADDR_FLAGS, 8'h00, 1'b0, 1'b1, 1'b1);
        chk({is_sfr_o, bank_o, rdata_o}, 16'h0200);
        acc(8'h30, 8'h00, 1'b0, 1'b0, 1'b0);
        chk(rdata_o, 8'h00);
        acc(sfr_core_pkg::ADDR_PC_LOW, 8'h34, 1'b1, 1'b0, 1'b0);
        chk({pc_load_o, dummy_cycle_o, pc_target_o}, 16'h7234);
        @(negedge clk_i);
        chk({pc_load_o, dummy_cycle_o}, 16'h0000);
        @(negedge clk_i);
        table_word_i = 16'habcd;
        table_read_i = 1'b1;
        @(negedge clk_i);
        table_read_i = 1'b0;
        chk({table_low_valid_o, table_low_o}, 16'h01cd);
        acc(sfr_core_pkg::ADDR_TBL_RESULT, 8'h00, 1'b0, 1'b0, 1'b0);
        chk(rdata_o, 8'hab);
        acc(sfr_core_pkg::ADDR_TBL_PTR_LO, 8'h5a, 1'b1, 1'b0, 1'b0);
        acc(sfr_core_pkg::ADDR_TBL_PTR_HI, 8'hff, 1'b1, 1'b0, 1'b0);
        chk(table_addr_o, 16'h1f5a);
        $display("registers done");
        do_reset(1'b1);
        chk(bank_select_bit_o, 16'h0001);
        do_reset(1'b0);
        chk({bank_select_bit_o, flags_o}, 16'h0000);
        $display("reset causes done");
        complete_run();
    end
endmodule : status_flags_and_bank_select_bench
